// *** tlb_pkg.sv ***
// Purpose: Shared constants and types for the TLB update and miss path
// Assumes: 32-bit APB register window, four ways of 32 sets
// Notes: Offsets are used by name; the control read-back and AST_STATUS also write bit positions as literals
package tlb_pkg;
    localparam int TLB_WAYS = 4;
    localparam int TLB_SETS = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTL = 8'h00;
    localparam logic [7:0] OFS_EHI = 8'h04;
    localparam logic [7:0] OFS_ELO = 8'h08;
    localparam logic [7:0] OFS_FAULT = 8'h0c;
    localparam logic [7:0] OFS_EVT = 8'h10;
    localparam logic [7:0] OFS_SPC = 8'h14;
    localparam logic [7:0] OFS_SSR = 8'h18;
    localparam logic [7:0] OFS_SR = 8'h1c;
    localparam logic [7:0] OFS_VBR = 8'h20;
    // Control register fields
    localparam int CTL_AT = 0;
    localparam int CTL_TF = 2;
    localparam int CTL_RC = 6;
    localparam int CTL_SV = 8;
    localparam int CTL_IX = 9;
    // Status word fields
    localparam int SR_MD = 30;
    localparam int SR_RB = 29;
    localparam int SR_BL = 28;
    // Entry low register fields
    localparam int ELO_PPN = 10;
    localparam int ELO_V = 8;
    localparam int ELO_PR = 5;
    localparam int ELO_SZ = 4;
    localparam int ELO_C = 3;
    localparam int ELO_D = 2;
    localparam int ELO_SH = 1;
    // Exception codes, vector offset and reset values
    localparam logic [11:0] EVT_MISS_LOAD = 12'h040;
    localparam logic [11:0] EVT_MISS_STORE = 12'h060;
    localparam logic [31:0] VEC_MISS_OFS = 32'h0000_0400;
    localparam logic [31:0] SR_RST = 32'h7000_0000;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // The four exception kinds; the unit reports only the miss kind
    typedef enum logic [1:0] {
        EXC_MISS = 2'b00,
        EXC_PROT = 2'b01,
        EXC_INVALID = 2'b10,
        EXC_FIRST_WRITE = 2'b11
    } tlb_exc_t;

    typedef struct packed {
        logic [21:0] virtual_page_number;
        logic [7:0] address_space_id;
        logic v;
        logic [18:0] physical_page_number;
        logic [1:0] pr;
        logic sz;
        logic c;
        logic d;
        logic sh;
    } tlb_entry_t;
endpackage : tlb_pkg

// *** tlb_cmp_if.sv ***
// Purpose: Carries one indexed set and the lookup key to the way comparators
// Assumes: Purely combinational traffic
// Notes: One bit per way in hit and valid
interface tlb_cmp_if import tlb_pkg::*; ();
    tlb_entry_t [3:0] set_e;
    logic [21:0] va_vpn;
    logic [7:0] address_space_id;
    logic ignore_address_space_id;
    logic [3:0] hit;
    logic [3:0] valid;
    modport host (output set_e, output va_vpn, output address_space_id, output ignore_address_space_id, input hit, input valid);
    modport cmp (input set_e, input va_vpn, input address_space_id, input ignore_address_space_id, output hit, output valid);
endinterface : tlb_cmp_if

// *** tlb_way_cmp.sv ***
// Purpose: Compares the lookup key against the four entries of one set
// Assumes: Entries already selected by set index
// Notes: No state; results settle within the cycle
module tlb_way_cmp
    import tlb_pkg::*;
(
    // Set and key
    tlb_cmp_if.cmp cmp
);
    ////////////////////////////////////////////////////////////////////////
    // One comparator per way, all searched at once
    for (genvar w = 0; w < TLB_WAYS; w++) begin : g_way
        logic vpn_eq;
        logic address_space_id_eq;
        // Low page bits only matter for small pages [R22]
        assign vpn_eq = (cmp.va_vpn[21:2] == cmp.set_e[w].virtual_page_number[21:2])
            && (cmp.set_e[w].sz || (cmp.va_vpn[1:0] == cmp.set_e[w].virtual_page_number[1:0]));
        // Shared pages and privileged single-space mode skip the identifier
        assign address_space_id_eq = cmp.set_e[w].sh || cmp.ignore_address_space_id || (cmp.address_space_id == cmp.set_e[w].address_space_id);
        // A hit needs the valid bit as well [R21]
        assign cmp.hit[w] = vpn_eq && address_space_id_eq && cmp.set_e[w].v;
        assign cmp.valid[w] = cmp.set_e[w].v;
    end
endmodule : tlb_way_cmp

// *** tlb_mmu.sv ***
// Purpose: TLB load path, flush and TLB-miss exception entry with APB registers
// Assumes: Core issues lookups and load ops on core_clk; APB shares the clock
// Notes: Lookup answers one cycle after the request edge
// How it works
// (R01) Writing one to the flush bit invalidates the TLB; mode changes should flush together.
// (R02) With translation off no MMU exception is raised for any access.
// (R03) Without hashing, load op writes both entry registers into the counted way.
// (R04) With hashing, set index is page bits 16-12 xor identifier bits 4-0.
// (R05) Every MMU exception loads the page number and a way into the counter.
// (R06) Software may pick any entry by rewriting entry high and the way counter.
// (R07) Software issues load op untranslated and waits two instructions before translated access.
// (R08) Software programs the control register only from untranslated areas.
// (R09) Cache index is virtual bits 11-4, cache tag physical bits 28-10.
// (R10) Software keeps bits 11-10 equal for aliased small pages.
// (R11) Exactly four exception kinds exist: miss, protection, invalid, first write.
// (R12) A miss is raised when no indexed way matches.
// (R13) On a miss, page number goes to entry high, full address to fault register.
// (R14) On a miss the event code is 040 for loads, 060 for stores.
// (R15) Saved PC holds the faulting instruction, or the owning branch for delay slots.
// (R16) Status is copied to saved status, then privilege, mask and bank bits set.
// (R17) Way counter increments when all ways valid, else takes lowest invalid way.
// (R18) Miss handler starts at vector base plus 400 hex.
// (R19) Handler fills entry low, may set the counter, runs load op and returns.
// (R20) Four ways of 32 entries, 128 in total.
// (R21) A hit needs matching keys and the entry valid bit set.
// (R22) Page bits 11-10 are compared only for small pages.
// (R23) Flush clears every valid bit in all four ways.
// (R24) All exception updates complete before the handler's first instruction.
//
// Chosen here: the register offsets and the APB register port.
module tlb_mmu
    import tlb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core lookup request
    input wire logic req_valid,
    input wire logic [31:0] req_vaddr,
    input wire logic req_store,
    input wire logic [31:0] req_pc,
    input wire logic req_in_slot,
    input wire logic [31:0] req_branch_pc,
    input wire logic load_tlb_op,
    // Lookup answer and cache address
    output logic resp_valid,
    output logic resp_hit,
    output logic [31:0] resp_paddr,
    output logic [7:0] cache_index,
    output logic [18:0] cache_tag,
    // Exception entry
    output logic exc_miss,
    output tlb_exc_t exc_kind,
    output logic [31:0] exc_vector
);
    typedef struct packed {
        tlb_entry_t [3:0][31:0] ent;
        logic at;
        logic sv;
        logic ix;
        logic [1:0] rc;
        logic [31:0] ehi;
        logic [31:0] elo;
        logic [31:0] fault;
        logic [11:0] evt;
        logic [31:0] saved_pc;
        logic [31:0] saved_status;
        logic [31:0] sr;
        logic [31:0] vector_base;
        logic [31:0] prdata;
        logic pslverr;
        logic resp_valid;
        logic resp_hit;
        logic [31:0] resp_paddr;
        logic [7:0] cache_idx;
        logic exc_miss;
        logic [31:0] exc_vector;
    } tlb_state_t;

    tlb_state_t state_r;
    tlb_state_t state_nxt;
    tlb_cmp_if cmp_bus ();
    logic [4:0] look_idx;
    logic [4:0] ld_idx;
    logic mapped;
    logic wr_acc;
    logic hit_any;
    logic [1:0] hit_way;
    logic [1:0] miss_way;
    logic any_valid;

    ////////////////////////////////////////////////////////////////////////
    // Set index from the request or entry high, hashed on demand
    assign look_idx = state_r.ix ? (req_vaddr[16:12] ^ state_r.ehi[4:0]) : req_vaddr[16:12]; // [R04]
    assign ld_idx = state_r.ix ? (state_r.ehi[16:12] ^ state_r.ehi[4:0]) : state_r.ehi[16:12]; // [R03] [R04]
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_VBR);
    assign wr_acc = psel && penable && pwrite && mapped;

    // Comparator feed; identifier ignored in privileged single-space mode
    assign cmp_bus.set_e = {state_r.ent[3][look_idx], state_r.ent[2][look_idx],
        state_r.ent[1][look_idx], state_r.ent[0][look_idx]};
    assign cmp_bus.va_vpn = req_vaddr[31:10];
    assign cmp_bus.address_space_id = state_r.ehi[7:0];
    assign cmp_bus.ignore_address_space_id = state_r.sv && state_r.sr[SR_MD];

    tlb_way_cmp u_cmp (
        .cmp(cmp_bus.cmp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Hit way and replacement way choice, lowest number first
    always_comb begin
        hit_way = 2'd0;
        miss_way = state_r.rc + 2'd1; // All ways valid: counter steps [R17]
        for (int w = TLB_WAYS - 1; w >= 0; w--) begin
            if (cmp_bus.hit[w]) begin
                hit_way = w[1:0];
            end
            if (!cmp_bus.valid[w]) begin
                miss_way = w[1:0]; // Lowest invalid way wins [R17]
            end
        end
    end
    assign hit_any = |cmp_bus.hit; // [R12]

    ////////////////////////////////////////////////////////////////////////
    // Next state: bus, load op, flush, lookup and miss entry
    always_comb begin
        state_nxt = state_r;
        state_nxt.resp_valid = 1'b0;
        state_nxt.exc_miss = 1'b0;
        // Read data is captured in the setup phase so the access phase needs no wait
        if (psel && !penable) begin
            state_nxt.pslverr = !mapped;
            unique case (paddr)
                OFS_CTL: state_nxt.prdata = {22'h0, state_r.ix, state_r.sv, state_r.rc, 5'h0, state_r.at};
                OFS_EHI: state_nxt.prdata = state_r.ehi;
                OFS_ELO: state_nxt.prdata = state_r.elo;
                OFS_FAULT: state_nxt.prdata = state_r.fault;
                OFS_EVT: state_nxt.prdata = {20'h0, state_r.evt};
                OFS_SPC: state_nxt.prdata = state_r.saved_pc;
                OFS_SSR: state_nxt.prdata = state_r.saved_status;
                OFS_SR: state_nxt.prdata = state_r.sr;
                OFS_VBR: state_nxt.prdata = state_r.vector_base;
                default: state_nxt.prdata = ZERO_RST;
            endcase
        end
        if (wr_acc) begin
            unique case (paddr)
                OFS_CTL: begin
                    state_nxt.at = pwdata[CTL_AT];
                    state_nxt.rc = pwdata[CTL_RC +: 2]; // [R06]
                    state_nxt.sv = pwdata[CTL_SV];
                    state_nxt.ix = pwdata[CTL_IX];
                end
                OFS_EHI: state_nxt.ehi = pwdata; // [R06]
                OFS_ELO: state_nxt.elo = pwdata;
                OFS_FAULT: state_nxt.fault = pwdata;
                OFS_EVT: state_nxt.evt = pwdata[11:0];
                OFS_SPC: state_nxt.saved_pc = pwdata;
                OFS_SSR: state_nxt.saved_status = pwdata;
                OFS_SR: state_nxt.sr = pwdata;
                OFS_VBR: state_nxt.vector_base = pwdata;
                default: state_nxt.vector_base = state_r.vector_base;
            endcase
        end
        // Load op writes both entry registers into the counted way
        if (load_tlb_op) begin
            state_nxt.ent[state_r.rc][ld_idx] = '{virtual_page_number: state_r.ehi[31:10], address_space_id: state_r.ehi[7:0], // [R03]
                v: state_r.elo[ELO_V], physical_page_number: state_r.elo[ELO_PPN +: 19], pr: state_r.elo[ELO_PR +: 2],
                sz: state_r.elo[ELO_SZ], c: state_r.elo[ELO_C], d: state_r.elo[ELO_D], sh: state_r.elo[ELO_SH]};
        end
        // Flush wins over a load op in the same cycle; the bit itself is not stored
        if (wr_acc && (paddr == OFS_CTL) && pwdata[CTL_TF]) begin
            for (int w = 0; w < TLB_WAYS; w++) begin
                for (int s = 0; s < TLB_SETS; s++) begin
                    state_nxt.ent[w][s].v = 1'b0; // [R01] [R23]
                end
            end
        end
        // Lookup; translation off passes the address straight through
        if (req_valid) begin
            state_nxt.resp_valid = 1'b1;
            state_nxt.cache_idx = req_vaddr[11:4]; // [R09]
            if (!state_r.at) begin
                state_nxt.resp_hit = 1'b1; // [R02]
                state_nxt.resp_paddr = req_vaddr;
            end else if (hit_any) begin
                state_nxt.resp_hit = 1'b1;
                state_nxt.resp_paddr = cmp_bus.set_e[hit_way].sz
                    ? {3'h0, cmp_bus.set_e[hit_way].physical_page_number[18:2], req_vaddr[11:0]}
                    : {3'h0, cmp_bus.set_e[hit_way].physical_page_number, req_vaddr[9:0]};
            end else begin
                // Miss entry: everything lands on one edge, before any handler fetch [R24]
                state_nxt.resp_hit = 1'b0;
                state_nxt.resp_paddr = ZERO_RST;
                state_nxt.exc_miss = 1'b1; // [R12]
                state_nxt.ehi = {req_vaddr[31:10], state_r.ehi[9:0]}; // [R05] [R13]
                state_nxt.fault = req_vaddr; // [R13]
                state_nxt.evt = req_store ? EVT_MISS_STORE : EVT_MISS_LOAD; // [R14]
                state_nxt.saved_pc = req_in_slot ? req_branch_pc : req_pc; // [R15]
                state_nxt.saved_status = state_r.sr; // [R16]
                state_nxt.sr = state_r.sr | (32'h1 << SR_MD) | (32'h1 << SR_BL) | (32'h1 << SR_RB); // [R16]
                state_nxt.rc = miss_way; // [R05] [R17]
                state_nxt.exc_vector = state_r.vector_base + VEC_MISS_OFS; // [R18]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; all 128 entries reset invalid [R20]
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
            state_r.sr <= SR_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = state_r.prdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && state_r.pslverr;
    assign resp_valid = state_r.resp_valid;
    assign resp_hit = state_r.resp_hit;
    assign resp_paddr = state_r.resp_paddr;
    assign cache_index = state_r.cache_idx;
    assign cache_tag = state_r.resp_paddr[28:10]; // [R09]
    assign exc_miss = state_r.exc_miss;
    assign exc_kind = EXC_MISS; // Only the miss kind is produced here [R11]
    assign exc_vector = state_r.exc_vector;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    always_comb begin
        any_valid = 1'b0;
        for (int w = 0; w < TLB_WAYS; w++) begin
            for (int s = 0; s < TLB_SETS; s++) begin
                any_valid = any_valid | state_r.ent[w][s].v;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_miss_req;
        req_valid && state_r.at && !hit_any;
    endsequence
    sequence s_miss_entry;
        exc_miss && !resp_hit && resp_valid;
    endsequence

    AST_FLUSH_CLEARS: assert property (wr_acc && paddr == OFS_CTL && pwdata[CTL_TF] |=> !any_valid) // [R01] [R23]
        else $error("flush left a valid entry");
    AST_OFF_NO_EXC: assert property (req_valid && !state_r.at |=> !exc_miss && resp_hit) // [R02]
        else $error("exception raised with translation off");
    AST_LOAD_WAY: assert property (load_tlb_op && !(wr_acc && paddr == OFS_CTL && pwdata[CTL_TF]) // [R03]
        |=> state_r.ent[$past(state_r.rc)][$past(ld_idx)].physical_page_number == $past(state_r.elo[ELO_PPN +: 19]))
        else $error("load op wrote wrong slot");
    AST_HASH_IDX: assert property (load_tlb_op && state_r.ix // [R04]
        && !(wr_acc && paddr == OFS_CTL && pwdata[CTL_TF])
        |=> state_r.ent[$past(state_r.rc)][$past(state_r.ehi[16:12] ^ state_r.ehi[4:0])].virtual_page_number
            == $past(state_r.ehi[31:10]))
        else $error("hashed load missed its set");
    AST_MISS_SEQ: assert property (s_miss_req |=> s_miss_entry) // [R12]
        else $error("miss not raised");
    AST_MISS_REGS: assert property (s_miss_req ##1 s_miss_entry // [R13]
        |-> state_r.fault == $past(req_vaddr) && state_r.ehi[31:10] == $past(req_vaddr[31:10]))
        else $error("fault registers not loaded");
    AST_EVT_CODE: assert property (s_miss_req |=> state_r.evt == ($past(req_store) ? 12'h060 : 12'h040)) // [R14]
        else $error("wrong event code");
    AST_SAVED_PC: assert property (s_miss_req |=> state_r.saved_pc == ($past(req_in_slot) ? $past(req_branch_pc) : $past(req_pc))) // [R15]
        else $error("saved PC wrong");
    AST_STATUS: assert property (s_miss_req |=> state_r.saved_status == $past(state_r.sr) && state_r.sr[30:28] == 3'h7) // [R16]
        else $error("status not saved or set");
    AST_WAY_STEP: assert property ((s_miss_req and (&cmp_bus.valid)) // [R17]
        |=> state_r.rc == $past(state_r.rc) + 2'd1)
        else $error("way counter did not step");
    AST_VECTOR: assert property (s_miss_req |=> exc_vector == $past(state_r.vector_base) + 32'h0000_0400) // [R18]
        else $error("miss vector wrong");
    AST_HIT_VALID: assert property (req_valid && state_r.at && !(|(cmp_bus.hit & cmp_bus.valid)) // [R21]
        |=> resp_valid && !resp_hit)
        else $error("hit on invalid entry");
endmodule : tlb_mmu

// *** tlb_core_model.sv ***
// Purpose: Behavioural core that issues lookups and load-TLB operations
// Assumes: Shares core_clk with the unit; drives right after rising edges
// Notes: Released request lines carry inverted data so stale values cannot pass
module tlb_core_model (
    // Clock
    input wire logic core_clk,
    // Lookup request towards the unit
    output logic req_valid,
    output logic [31:0] req_vaddr,
    output logic req_store,
    output logic [31:0] req_pc,
    output logic req_in_slot,
    output logic [31:0] req_branch_pc,
    // Load-TLB instruction pulse
    output logic load_tlb_op
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle values at time zero
    initial begin
        req_valid = 1'b0;
        req_vaddr = 32'h0000_0000;
        req_store = 1'b0;
        req_pc = 32'h0000_0000;
        req_in_slot = 1'b0;
        req_branch_pc = 32'h0000_0000;
        load_tlb_op = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One access; returns just after the edge that carries the answer
    task automatic issue(input logic [31:0] va, input logic st, input logic [31:0] pc, input logic slot,
                         input logic [31:0] bpc);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_vaddr <= va;
        req_store <= st;
        req_pc <= pc;
        req_in_slot <= slot;
        req_branch_pc <= bpc;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req_vaddr <= ~va;
        req_store <= ~st;
        req_pc <= ~pc;
        req_in_slot <= ~slot;
        req_branch_pc <= ~bpc;
        #1;
    endtask : issue

    // Load-TLB, then two idle slots before any translated access
    task automatic load_op();
        @(posedge core_clk);
        load_tlb_op <= 1'b1;
        @(posedge core_clk);
        load_tlb_op <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : load_op
endmodule : tlb_core_model

// *** tlb_update_and_miss_trap_tb.sv ***
// Purpose: Self-checking bench for the TLB load path and miss entry
// Assumes: Zero-wait APB slave; lookup answers one cycle after request
// Notes: Only 4-kbyte pages are loaded, so no cache synonyms arise
module tlb_update_and_miss_trap_tb
    import tlb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] VA1 = 32'h0001_2345;
    localparam logic [31:0] VECTOR_BASE = 32'h0000_8000;
    localparam logic [31:0] PC = 32'h0000_1100;
    localparam logic [31:0] BPC = 32'h0000_10fe;
    localparam logic [31:0] ELO = 32'h0ab4_c000 | (32'h1 << ELO_V) | (32'h1 << ELO_SZ) | (32'h3 << ELO_PR) | 32'h4;
    localparam logic [31:0] AT = 32'h1 << CTL_AT;
    localparam logic [31:0] TF = 32'h1 << CTL_TF;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, resp_paddr, exc_vector, req_vaddr, req_pc, req_branch_pc, rd;
    logic pready, pslverr, resp_valid, resp_hit, exc_miss, req_valid, req_store, req_in_slot, load_tlb_op, err;
    logic [7:0] cache_index;
    logic [18:0] cache_tag;
    tlb_exc_t exc_kind;
    int err_total = 0;
    int n_compared = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, unit and core
    always #12.5 core_clk = ~core_clk;
    tlb_mmu tlb_mmu_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_vaddr(req_vaddr), .req_store(req_store), .req_pc(req_pc),
        .req_in_slot(req_in_slot), .req_branch_pc(req_branch_pc), .load_tlb_op(load_tlb_op),
        .resp_valid(resp_valid), .resp_hit(resp_hit), .resp_paddr(resp_paddr), .cache_index(cache_index),
        .cache_tag(cache_tag), .exc_miss(exc_miss), .exc_kind(exc_kind), .exc_vector(exc_vector));
    tlb_core_model core_i (.core_clk(core_clk), .req_valid(req_valid), .req_vaddr(req_vaddr),
        .req_store(req_store), .req_pc(req_pc), .req_in_slot(req_in_slot), .req_branch_pc(req_branch_pc),
        .load_tlb_op(load_tlb_op));

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, rd & mask, exp);
    endtask : rdchk

    task automatic look(input logic [31:0] va, input logic st, input logic slot, input logic hit);
        core_i.issue(va, st, PC, slot, BPC);
        chk("resp_valid", resp_valid, 32'h1);
        chk("resp_hit", resp_hit, hit);
        chk("exc_miss", exc_miss, !hit);
    endtask : look

    // Everything the hardware leaves behind on a miss
    task automatic miss_regs(input logic [31:0] va, input logic [11:0] evt, input logic [31:0] saved_pc,
                             input logic [31:0] saved_status, input logic [1:0] way);
        chk("exc_vector", exc_vector, VECTOR_BASE + VEC_MISS_OFS);
        chk("exc_kind", exc_kind, EXC_MISS);
        rdchk("ehi_vpn", OFS_EHI, 32'hffff_fc00, va & 32'hffff_fc00);
        rdchk("fault", OFS_FAULT, 32'hffff_ffff, va);
        rdchk("evt", OFS_EVT, 32'h0000_0fff, evt);
        rdchk("spc", OFS_SPC, 32'hffff_ffff, saved_pc);
        rdchk("ssr", OFS_SSR, 32'hffff_ffff, saved_status);
        rdchk("sr", OFS_SR, 32'hffff_ffff, SR_RST);
        rdchk("rc", OFS_CTL, 32'h0000_00c0, 32'(way) << CTL_RC);
    endtask : miss_regs

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; control is only rewritten with no lookup in flight
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rdchk("sr_reset", OFS_SR, 32'hffff_ffff, SR_RST);
        rdchk("ctl_reset", OFS_CTL, 32'hffff_ffff, 32'h0000_0000);
        apb(1'b1, 8'h24, 32'hffff_ffff);
        chk("unmapped_err", err, 32'h1);
        rdchk("unmapped_rd", 8'h24, 32'hffff_ffff, 32'h0000_0000);
        look(VA1, 1'b1, 1'b0, 1'b1);
        chk("paddr_off", resp_paddr, VA1);
        apb(1'b1, OFS_VBR, VECTOR_BASE);
        apb(1'b1, OFS_SR, 32'h0000_0000);
        apb(1'b1, OFS_CTL, AT | TF);
        look(VA1, 1'b1, 1'b0, 1'b0);
        miss_regs(VA1, EVT_MISS_STORE, PC, 32'h0000_0000, 2'd0);
        // Handler style refill: low register only, then load
        apb(1'b1, OFS_ELO, ELO);
        core_i.load_op();
        look(VA1, 1'b0, 1'b0, 1'b1);
        chk("paddr", resp_paddr, {3'h0, ELO[28:12], VA1[11:0]});
        chk("cache_index", cache_index, VA1[11:4]);
        chk("cache_tag", cache_tag, ELO[28:10]);
        look(32'h0041_2008, 1'b0, 1'b1, 1'b0);
        miss_regs(32'h0041_2008, EVT_MISS_LOAD, BPC, SR_RST, 2'd1);
        core_i.load_op();
        // Software picks ways 2 and 3 of the same set
        for (int w = 2; w < 4; w++) begin
            apb(1'b1, OFS_EHI, 32'h0001_2000 | (32'(w) << 22));
            apb(1'b1, OFS_CTL, AT | (32'(w) << CTL_RC));
            core_i.load_op();
        end
        look(32'h00c1_2000, 1'b0, 1'b0, 1'b1);
        look(32'h0041_2008, 1'b0, 1'b0, 1'b1);
        apb(1'b1, OFS_CTL, AT | (32'h1 << CTL_RC));
        look(32'h0101_2000, 1'b0, 1'b0, 1'b0);
        rdchk("rc_inc", OFS_CTL, 32'h0000_00c0, 32'h2 << CTL_RC);
        // Hashed load lands in set 2; identifier 1 hashes page 3 onto it, so the miss sees way 0 taken
        apb(1'b1, OFS_CTL, AT | TF | (32'h1 << CTL_IX));
        apb(1'b1, OFS_EHI, 32'h0000_1003);
        core_i.load_op();
        apb(1'b1, OFS_EHI, 32'h0000_0001);
        look(32'h0000_3000, 1'b0, 1'b0, 1'b0);
        rdchk("rc_hash", OFS_CTL, 32'h0000_00c0, 32'h1 << CTL_RC);
        apb(1'b1, OFS_CTL, AT | TF);
        rdchk("tf_read", OFS_CTL, TF, 32'h0000_0000);
        look(32'h0000_2000, 1'b0, 1'b0, 1'b0);
        rdchk("rc_flush", OFS_CTL, 32'h0000_00c0, 32'h0000_0000);
        // Identifier ignored only in single-space mode with privilege set
        apb(1'b1, OFS_CTL, AT | TF | (32'h1 << CTL_SV));
        apb(1'b1, OFS_EHI, 32'h0000_4005);
        core_i.load_op();
        apb(1'b1, OFS_EHI, 32'h0000_0009);
        look(32'h0000_4000, 1'b0, 1'b0, 1'b1);
        apb(1'b1, OFS_SR, 32'h0000_0000);
        look(32'h0000_4000, 1'b0, 1'b0, 1'b0);
        results();
    end

    // Watchdog sized far above the roughly 170 cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end
endmodule : tlb_update_and_miss_trap_tb
